// ---- hdl/bls_top.sv ----
// Chosen here: the plain strobed port.
`timescale 1ns/1ps
// Behaviour
// R1: sampling phase chosen among 64 positions
// R2: lock needs only pixels-per-line setting
// R3: servo nulls each channel's black level
// R4: one quarter-code step, slow rate
// R5: converged codes hold while error zero
// R6: user offset shifts black plus/minus 64; code applies the shift only with the servo on
// R7: servo off: firmware DAC codes held
// R8: gain never touches offset path
// R9: three gain registers at 0x06-0x08
// R10: nominal offset gives black 0x00/0x80
// R11: no colour-space conversion performed
// R12: config bit selects YUV mid-scale black
// R13: 4:4:4 maps Y green, U blue, V red
// R14: 4:2:2 blue low, red alternates U/V
// R15: alternation restarts after each sync
// R16: DAC code saturates, never wraps
module bls_top
	import bls_pkg::*;
#(
	parameter int LINE_W = 12
) (
	input  wire logic              clk,
	input  wire logic              nrst,
	input  wire logic [7:0]        regAddr,
	input  wire logic [7:0]        regWrData,
	input  wire logic              regWr,
	input  wire logic              regRd,
	output logic [7:0]             regRdData,
	input  wire logic              pixClk,
	input  wire logic              hsync,
	input  wire logic [9:0]        adcRed,
	input  wire logic [9:0]        adcGreen,
	input  wire logic [9:0]        adcBlue,
	output logic [9:0]             dacRed,
	output logic [9:0]             dacGreen,
	output logic [9:0]             dacBlue,
	output logic [7:0]             gainRed,
	output logic [7:0]             gainGreen,
	output logic [7:0]             gainBlue,
	output logic [5:0]             samplePhase,
	output logic [LINE_W-1:0]      lineLength,
	output logic [7:0]             outRed,
	output logic [7:0]             outGreen,
	output logic [7:0]             outBlue,
	output logic                   outValid,
	input  wire logic              outReady
);
	import bls_pkg::*;
	if (LINE_W < 12) begin
		$error("line width too small");
	end
	if (SERVO_PERIOD_LINES > 32) begin
		$error("servo pace does not fit its line divider");
	end
	// ------------------------------------------------------------
	// input synchronisers
	// ------------------------------------------------------------
	logic [1:0] pixSync_reg;
	logic [1:0] hsSync_reg;
	logic       pixPrev_reg;
	logic       hsPrev_reg;
	logic       pixEdge;
	logic       hsFall;
	logic [9:0] adcMeta_reg [3];
	logic [9:0] adcSafe_reg [3];
	// two-flop sync of link clock and sync
	always_ff @(posedge clk) begin
		if (!nrst) begin
			pixSync_reg <= '0;
			hsSync_reg  <= '0;
			pixPrev_reg <= 1'b0;
			hsPrev_reg  <= 1'b0;
		end else begin
			pixSync_reg <= {pixSync_reg[0], pixClk};
			hsSync_reg  <= {hsSync_reg[0], hsync};
			pixPrev_reg <= pixSync_reg[1];
			if (pixEdge) hsPrev_reg <= hsSync_reg[1]; // sync level at the last pixel
		end
	end
	// two-flop sync of the sample words; they settle long before a pixel edge
	always_ff @(posedge clk) begin
		if (!nrst) begin
			for (int i = 0; i < 3; i++) begin
				adcMeta_reg[i] <= '0;
				adcSafe_reg[i] <= '0;
			end
		end else begin
			adcMeta_reg[0] <= adcRed;
			adcMeta_reg[1] <= adcGreen;
			adcMeta_reg[2] <= adcBlue;
			for (int i = 0; i < 3; i++) adcSafe_reg[i] <= adcMeta_reg[i];
		end
	end
	// one-cycle pulses: link clock rise, sync trailing edge seen at a pixel
	assign pixEdge = pixSync_reg[1] && !pixPrev_reg;
	assign hsFall  = pixEdge && !hsSync_reg[1] && hsPrev_reg; // sync trailing edge
	// ------------------------------------------------------------
	// register file
	// ------------------------------------------------------------
	logic [7:0]  gain_reg [3];
	logic [7:0]  userOfs_reg [3];
	logic [9:0]  manDac_reg [3];
	logic [1:0]  dacLow_reg [3];
	logic        yuv_reg;
	logic        fmt422_reg;
	logic        servoOff_reg;
	logic [11:0] lineLen_reg;
	logic [5:0]  phase_reg;
	logic [9:0]  dac_reg [3];
	logic        locked_reg;
	// software writes
	always_ff @(posedge clk) begin
		if (!nrst) begin
			for (int i = 0; i < 3; i++) begin
				gain_reg[i]    <= GAIN_RESET;
				userOfs_reg[i] <= OFS_NOMINAL;
				dacLow_reg[i]  <= '0;
			end
			yuv_reg      <= 1'b0;
			fmt422_reg   <= 1'b0;
			servoOff_reg <= 1'b0;
			lineLen_reg  <= LINE_LEN_RESET;
			phase_reg    <= '0;
		end else if (regWr) begin
			case (regAddr)
				ADDR_GAIN_FIRST:  gain_reg[0] <= regWrData; // [R9]
				ADDR_GAIN_SECOND: gain_reg[1] <= regWrData; // [R9]
				ADDR_GAIN_THIRD:  gain_reg[2] <= regWrData; // [R9]
				ADDR_RED_OFS:     userOfs_reg[0] <= regWrData;
				ADDR_GREEN_OFS:   userOfs_reg[1] <= regWrData;
				ADDR_BLUE_OFS:    userOfs_reg[2] <= regWrData;
				ADDR_DAC_LOW: begin
					dacLow_reg[0] <= regWrData[7:6];
					dacLow_reg[1] <= regWrData[5:4];
					dacLow_reg[2] <= regWrData[3:2];
				end
				ADDR_CONFIG:      yuv_reg <= regWrData[CFG_YUV_BIT]; // [R12]
				ADDR_OUT_FMT:     fmt422_reg <= regWrData[FMT_422_BIT]; // [R14]
				ADDR_SERVO_CTRL:  servoOff_reg <= regWrData[SERVO_OFF_BIT]; // [R7]
				ADDR_LINE_LEN_LO: lineLen_reg[7:0] <= regWrData; // [R2]
				ADDR_LINE_LEN_HI: lineLen_reg[11:8] <= regWrData[3:0]; // [R2]
				ADDR_PHASE:       phase_reg <= regWrData[5:0]; // [R1]
				default: ;
			endcase
		end
	end
	// manual DAC code: offset byte high, low pair from shared register
	always_comb begin
		for (int i = 0; i < 3; i++) begin
			manDac_reg[i] = {userOfs_reg[i], dacLow_reg[i]}; // [R7]
		end
	end
	// read data, one cycle after strobe
	always_ff @(posedge clk) begin
		if (!nrst) begin
			regRdData <= READ_ZERO;
		end else if (regRd) begin
			case (regAddr)
				ADDR_GAIN_FIRST:  regRdData <= gain_reg[0];
				ADDR_GAIN_SECOND: regRdData <= gain_reg[1];
				ADDR_GAIN_THIRD:  regRdData <= gain_reg[2];
				ADDR_RED_OFS:     regRdData <= userOfs_reg[0];
				ADDR_GREEN_OFS:   regRdData <= userOfs_reg[1];
				ADDR_BLUE_OFS:    regRdData <= userOfs_reg[2];
				ADDR_DAC_LOW:     regRdData <= {dacLow_reg[0], dacLow_reg[1], dacLow_reg[2], 2'b00};
				ADDR_CONFIG:      regRdData <= 8'(yuv_reg) << CFG_YUV_BIT;
				ADDR_OUT_FMT:     regRdData <= 8'(fmt422_reg) << FMT_422_BIT;
				ADDR_SERVO_CTRL:  regRdData <= 8'(servoOff_reg) << SERVO_OFF_BIT;
				ADDR_LINE_LEN_LO: regRdData <= lineLen_reg[7:0];
				ADDR_LINE_LEN_HI: regRdData <= {4'h0, lineLen_reg[11:8]};
				ADDR_PHASE:       regRdData <= {2'b00, phase_reg};
				ADDR_DAC_RD_R:    regRdData <= dac_reg[0][9:2];
				ADDR_DAC_RD_G:    regRdData <= dac_reg[1][9:2];
				ADDR_DAC_RD_B:    regRdData <= dac_reg[2][9:2];
				ADDR_STATUS:      regRdData <= {7'h00, locked_reg};
				default:          regRdData <= READ_ZERO;
			endcase
		end else begin
			regRdData <= READ_ZERO;
		end
	end
	// ------------------------------------------------------------
	// line timing on pixel edges
	// ------------------------------------------------------------
	logic [11:0]  pixCnt_reg;
	bls_line_type line_reg;
	logic [4:0]   lineDiv_reg;
	logic         servoTick;
	logic         porch;
	// pixel counter and line phase
	always_ff @(posedge clk) begin
		if (!nrst) begin
			pixCnt_reg  <= '0;
			line_reg    <= ST_SYNC;
			lineDiv_reg <= '0;
			locked_reg  <= 1'b0;
		end else if (hsFall) begin
			locked_reg  <= ((pixCnt_reg + 1'b1) == lineLen_reg); // [R2] edges since last sync
			pixCnt_reg  <= '0;
			line_reg    <= ST_PORCH;
			lineDiv_reg <= (lineDiv_reg == 5'(SERVO_PERIOD_LINES - 1)) ? '0 : lineDiv_reg + 1'b1;
		end else if (pixEdge) begin
			pixCnt_reg <= pixCnt_reg + 1'b1;
			case (line_reg)
				ST_PORCH: begin
					if (pixCnt_reg == 12'(BACK_PORCH_START + BACK_PORCH_LEN)) line_reg <= ST_VIDEO;
				end
				ST_VIDEO: begin
					if (hsSync_reg[1] || pixCnt_reg == lineLen_reg) line_reg <= ST_SYNC;
				end
				ST_SYNC: ;
				default: line_reg <= ST_SYNC;
			endcase
		end
	end
	// porch window and servo pace
	assign porch     = line_reg == ST_PORCH && pixCnt_reg >= 12'(BACK_PORCH_START);
	assign servoTick = hsFall && lineDiv_reg == '0; // [R4] one step per many lines
	// ------------------------------------------------------------
	// black-level servo
	// ------------------------------------------------------------
	logic [9:0] adc [3];
	logic [9:0] target [3];
	logic [1:0] errSign_reg [3];
	assign adc[0] = adcSafe_reg[0];
	assign adc[1] = adcSafe_reg[1];
	assign adc[2] = adcSafe_reg[2];
	// black target: mid-scale on the colour-difference channels in YUV
	always_comb begin
		for (int i = 0; i < 3; i++) begin
			if (yuv_reg && i != 1) target[i] = {BLACK_MID, 2'b00}; // [R12]
			else target[i] = {BLACK_ZERO, 2'b00}; // [R10]
		end
	end
	// sample black error in back porch; adc in quarter codes
	always_ff @(posedge clk) begin
		if (!nrst) begin
			for (int i = 0; i < 3; i++) errSign_reg[i] <= 2'b00;
		end else if (pixEdge && porch) begin
			for (int i = 0; i < 3; i++) begin
				if (adc[i] > target[i]) errSign_reg[i] <= 2'b01; // [R3] above target
				else if (adc[i] < target[i]) errSign_reg[i] <= 2'b10; // [R3] below target
				else errSign_reg[i] <= 2'b00; // [R5] at target
			end
		end
	end
	// DAC step, saturating; gain never enters here
	always_ff @(posedge clk) begin
		if (!nrst) begin
			for (int i = 0; i < 3; i++) dac_reg[i] <= DAC_MID;
		end else begin
			for (int i = 0; i < 3; i++) begin
				if (servoOff_reg) begin
					dac_reg[i] <= manDac_reg[i]; // [R7]
				end else if (servoTick && errSign_reg[i] == 2'b01) begin
					if (dac_reg[i] != DAC_MIN) dac_reg[i] <= dac_reg[i] - 1'b1; // [R3] [R4] [R16]
				end else if (servoTick && errSign_reg[i] == 2'b10) begin
					if (dac_reg[i] != DAC_MAX) dac_reg[i] <= dac_reg[i] + 1'b1; // [R3] [R4] [R16]
				end
			end
		end
	end
	// dac, gain, phase and length outputs
	assign dacRed      = dac_reg[0];
	assign dacGreen    = dac_reg[1];
	assign dacBlue     = dac_reg[2];
	assign gainRed     = gain_reg[0]; // [R8] separate path
	assign gainGreen   = gain_reg[1];
	assign gainBlue    = gain_reg[2];
	assign samplePhase = phase_reg; // [R1]
	assign lineLength  = LINE_W'(lineLen_reg);
	// ------------------------------------------------------------
	// digital offset and output format
	// ------------------------------------------------------------
	logic [7:0] pix [3];
	logic       cbPhase_reg;
	// user offset adder, limited to its span, clamp to 8 bits
	always_comb begin
		for (int i = 0; i < 3; i++) begin
			logic signed [11:0] d;
			logic signed [11:0] v;
			d = 12'(userOfs_reg[i]) - 12'(OFS_NOMINAL);
			if (d > 12'(OFS_SPAN)) d = 12'(OFS_SPAN); // [R6] span limit
			else if (d < -12'(OFS_SPAN)) d = -12'(OFS_SPAN);
			v = 12'(adc[i][9:2]) + d; // [R6] [R10]
			if (servoOff_reg) v = 12'(adc[i][9:2]); // [R6] adder only with servo on
			if (v < 0) pix[i] = 8'h00;
			else if (v > 12'sd255) pix[i] = 8'hFF;
			else pix[i] = v[7:0];
		end
	end
	// 4:2:2 chroma phase, reset each line
	always_ff @(posedge clk) begin
		if (!nrst) cbPhase_reg <= 1'b1;
		else if (hsFall) cbPhase_reg <= 1'b1; // [R15]
		else if (pixEdge && line_reg == ST_VIDEO) cbPhase_reg <= !cbPhase_reg;
	end
	// ------------------------------------------------------------
	// pixel buffer
	// ------------------------------------------------------------
	// word packing per output format
	bls_skid_if #(.W(24)) skid ();
	logic [23:0] word;
	always_comb begin
		if (yuv_reg && fmt422_reg) begin
			word = {cbPhase_reg ? pix[2] : pix[0], pix[1], 8'h00}; // [R14]
		end else begin
			word = {pix[0], pix[1], pix[2]}; // [R11] [R13]
		end
	end
	// one word per active pixel; a full buffer drops it
	assign skid.inValid  = pixEdge && line_reg == ST_VIDEO;
	assign skid.inData   = word;
	assign skid.outReady = outReady;
	bls_skid_buffer #(.W(24), .DEPTH(2)) u_buf (
		.clk  (clk),
		.nrst (nrst),
		.port (skid.buff)
	);
	// ------------------------------------------------------------
	// registered pixel port
	// ------------------------------------------------------------
	// head of buffer, one cycle late
	always_ff @(posedge clk) begin
		if (!nrst) begin
			outRed   <= '0;
			outGreen <= '0;
			outBlue  <= '0;
		end else begin
			outRed   <= skid.outData[23:16];
			outGreen <= skid.outData[15:8];
			outBlue  <= skid.outData[7:0];
		end
	end
	assign outValid = skid.outValid;
endmodule

// ---- hdl/bls_pkg.sv ----
package bls_pkg;
	// ------------------------------------------------------------
	// register map, byte offsets
	// ------------------------------------------------------------
	localparam logic [7:0] ADDR_GAIN_FIRST  = 8'h06;
	localparam logic [7:0] ADDR_GAIN_SECOND = 8'h07;
	localparam logic [7:0] ADDR_GAIN_THIRD  = 8'h08;
	localparam logic [7:0] ADDR_RED_OFS     = 8'h09;
	localparam logic [7:0] ADDR_GREEN_OFS   = 8'h0A;
	localparam logic [7:0] ADDR_BLUE_OFS    = 8'h0B;
	localparam logic [7:0] ADDR_DAC_LOW     = 8'h0C;
	localparam logic [7:0] ADDR_CONFIG      = 8'h05;
	localparam logic [7:0] ADDR_SERVO_CTRL  = 8'h17;
	localparam logic [7:0] ADDR_OUT_FMT     = 8'h18;
	localparam logic [7:0] ADDR_LINE_LEN_LO = 8'h01;
	localparam logic [7:0] ADDR_LINE_LEN_HI = 8'h02;
	localparam logic [7:0] ADDR_PHASE       = 8'h03;
	localparam logic [7:0] ADDR_DAC_RD_R    = 8'h20;
	localparam logic [7:0] ADDR_DAC_RD_G    = 8'h21;
	localparam logic [7:0] ADDR_DAC_RD_B    = 8'h22;
	localparam logic [7:0] ADDR_STATUS      = 8'h24;
	// ------------------------------------------------------------
	// fields and reset values
	// ------------------------------------------------------------
	localparam int          CFG_YUV_BIT     = 2;
	localparam int          FMT_422_BIT     = 4;
	localparam int          SERVO_OFF_BIT   = 0;
	localparam int          DAC_W           = 10;
	localparam int          PHASE_STEPS     = 64;
	localparam logic [7:0]  GAIN_RESET      = 8'h55;
	localparam logic [7:0]  OFS_NOMINAL     = 8'h80;
	localparam logic [7:0]  BLACK_MID       = 8'h80;
	localparam logic [7:0]  BLACK_ZERO      = 8'h00;
	localparam logic [9:0]  DAC_MID         = 10'h200;
	localparam logic [9:0]  DAC_MAX         = 10'h3FF;
	localparam logic [9:0]  DAC_MIN         = 10'h000;
	localparam logic [11:0] LINE_LEN_RESET  = 12'h0320;
	localparam logic [7:0]  READ_ZERO       = 8'h00;
	localparam int          OFS_SPAN        = 64;
	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int SERVO_PERIOD_LINES = 16;
	localparam int BACK_PORCH_START   = 4;
	localparam int BACK_PORCH_LEN     = 8;
	typedef enum logic [1:0] {
		ST_SYNC  = 2'b00,
		ST_PORCH = 2'b01,
		ST_VIDEO = 2'b10
	} bls_line_type;
endpackage

// ---- hdl/bls_skid_if.sv ----
`timescale 1ns/1ps
interface bls_skid_if #(parameter int W = 24);
	logic         inValid;
	logic         inReady;
	logic [W-1:0] inData;
	logic         outValid;
	logic         outReady;
	logic [W-1:0] outData;
	modport src  (output inValid, output inData, input inReady, input outValid, input outData, output outReady);
	modport buff (input inValid, input inData, output inReady, output outValid, output outData, input outReady);
endinterface

// ---- hdl/bls_skid_buffer.sv ----
`timescale 1ns/1ps
module bls_skid_buffer #(
	parameter int W     = 24,
	parameter int DEPTH = 2
) (
	input wire logic clk,
	input wire logic nrst,
	bls_skid_if.buff port
);
	localparam int AW = $clog2(DEPTH);
	if (DEPTH != 2) begin
		$error("depth must be 2");
	end
	logic [W-1:0]  mem_reg [DEPTH];
	logic [AW-1:0] wrPtr_reg;
	logic [AW-1:0] rdPtr_reg;
	logic [AW:0]   count_reg;
	logic          push;
	logic          pop;
	// handshake terms
	assign port.inReady  = count_reg < (AW+1)'(DEPTH);
	assign port.outValid = count_reg != '0;
	assign port.outData  = mem_reg[rdPtr_reg];
	assign push          = port.inValid && port.inReady;
	assign pop           = port.outValid && port.outReady;
	// storage
	always_ff @(posedge clk) begin
		if (push) begin
			mem_reg[wrPtr_reg] <= port.inData;
		end
	end
	// pointers and fill count
	always_ff @(posedge clk) begin
		if (!nrst) begin
			wrPtr_reg <= '0;
			rdPtr_reg <= '0;
			count_reg <= '0;
		end else begin
			if (push) wrPtr_reg <= wrPtr_reg + 1'b1;
			if (pop) rdPtr_reg <= rdPtr_reg + 1'b1;
			count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule

// ---- test/bls_top_chk.sv ----
`timescale 1ns/1ps
// watches register writes, offset dac codes and the pixel port
module bls_top_chk
	import bls_pkg::*;
#(
	parameter int LINE_W = 12
) (
	input wire logic              clk,
	input wire logic              nrst,
	input wire logic [7:0]        regAddr,
	input wire logic [7:0]        regWrData,
	input wire logic              regWr,
	input wire logic [9:0]        dacRed,
	input wire logic [9:0]        dacGreen,
	input wire logic [9:0]        dacBlue,
	input wire logic [7:0]        gainRed,
	input wire logic [5:0]        samplePhase,
	input wire logic [LINE_W-1:0] lineLength,
	input wire logic [7:0]        outBlue,
	input wire logic              outValid,
	input wire logic              outReady
);
	import bls_pkg::*;
	logic       offReg;
	logic       fmtReg;
	logic [6:0] fmtCnt;
	// servo and format modes mirrored from register writes
	always_ff @(posedge clk) begin
		if (!nrst) begin
			offReg <= 1'b0;
			fmtReg <= 1'b0;
		end else if (regWr && regAddr == ADDR_SERVO_CTRL) begin
			offReg <= regWrData[SERVO_OFF_BIT];
		end else if (regWr && regAddr == ADDR_OUT_FMT) begin
			fmtReg <= regWrData[FMT_422_BIT];
		end
	end
	// cycles spent in 4:2:2, saturating, so older words have drained
	always_ff @(posedge clk) begin
		if (!nrst || !fmtReg) begin
			fmtCnt <= 7'h00;
		end else if (fmtCnt != 7'h7F) begin
			fmtCnt <= fmtCnt + 7'h01;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	a_phase_write: assert property (regWr && regAddr == ADDR_PHASE |=> samplePhase == $past(regWrData[5:0]))
		else $error("sampling phase does not follow its register");
	a_len_write: assert property (regWr && regAddr == ADDR_LINE_LEN_LO |=> lineLength[7:0] == $past(regWrData))
		else $error("line length low byte not taken");
	a_gain_map: assert property (regWr && regAddr == ADDR_GAIN_FIRST |=> gainRed == $past(regWrData))
		else $error("first gain register not on red gain");
	a_servo_step: assert property (!offReg && $past(offReg) == 1'b0 && dacRed != $past(dacRed)
		|-> dacRed == $past(dacRed) + 10'h001 || dacRed == $past(dacRed) - 10'h001)
		else $error("servo moved red dac by more than one step");
	a_servo_slow: assert property (!offReg && $past(offReg) == 1'b0 && $changed(dacGreen)
		|=> $stable(dacGreen) [*8])
		else $error("servo stepped green dac too fast");
	a_dac_floor: assert property (!offReg && $past(offReg) == 1'b0 && $past(dacRed) == DAC_MIN
		|-> dacRed != DAC_MAX)
		else $error("red dac wrapped below zero");
	a_manual_hold: assert property (offReg && $past(offReg) && !$past(regWr) && !$past(regWr, 2)
		|-> $stable(dacBlue))
		else $error("blue dac moved while servo off");
	a_gain_apart: assert property (offReg && regWr && regAddr == ADDR_GAIN_SECOND |=> $stable(dacGreen) [*3])
		else $error("gain write disturbed green dac");
	a_blue_low: assert property (fmtCnt == 7'h7F && $past(outValid) && $past(outReady) |-> outBlue == 8'h00)
		else $error("blue output not low in 4:2:2");
endmodule
bind bls_top bls_top_chk #(.LINE_W(LINE_W)) u_chk (.clk(clk), .nrst(nrst), .regAddr(regAddr),
	.regWrData(regWrData), .regWr(regWr), .dacRed(dacRed), .dacGreen(dacGreen), .dacBlue(dacBlue),
	.gainRed(gainRed), .samplePhase(samplePhase), .lineLength(lineLength), .outBlue(outBlue),
	.outValid(outValid), .outReady(outReady));

// ---- test/bls_sink_model.sv ----
`timescale 1ns/1ps
// display-side sink: stalls on request, latches each accepted pixel
module bls_sink_model (
	input  wire logic       clk,
	input  wire logic       nrst,
	input  wire logic       hold,
	input  wire logic       slow,
	input  wire logic       outValid,
	input  wire logic [7:0] outRed,
	input  wire logic [7:0] outGreen,
	input  wire logic [7:0] outBlue,
	output logic            outReady
);
	int         capCount;
	logic [7:0] lastR;
	logic [7:0] lastG;
	logic [7:0] lastB;
	logic [1:0] phaseReg;
	logic       takenReg;
	// ready always, one cycle in four, or never
	always_ff @(posedge clk) begin
		phaseReg <= nrst ? phaseReg + 2'h1 : 2'h0;
		outReady <= nrst && !hold && (!slow || phaseReg == 2'h0);
	end
	// pixel stands in the cycle after its handshake
	always_ff @(posedge clk) begin
		takenReg <= nrst && outValid && outReady;
		if (!nrst) begin
			capCount <= 0;
		end else if (takenReg) begin
			capCount <= capCount + 1;
			lastR <= outRed;
			lastG <= outGreen;
			lastB <= outBlue;
		end
	end
endmodule

// ---- test/bls_top_tb.sv ----
`timescale 1ns/1ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin bad_count++; $display("BAD %s exp %h got %h", nm, e, g); end end
module bls_top_tb;
	import bls_pkg::*;
	localparam int LINE_PIX = 41;
	typedef struct packed {logic [7:0] a; logic [7:0] d; logic [7:0] q;} bls_reg_type;
	typedef struct packed {logic y; logic [7:0] o; logic [9:0] r, g, b; logic [7:0] er, eg, eb;} bls_pix_type;
	localparam bls_reg_type REGS [7] = '{'{ADDR_GAIN_FIRST, 8'h11, 8'h11}, '{ADDR_GAIN_SECOND, 8'h22, 8'h22},
		'{ADDR_GAIN_THIRD, 8'h33, 8'h33}, '{ADDR_PHASE, 8'h3F, 8'h3F}, '{ADDR_LINE_LEN_LO, 8'h29, 8'h29},
		'{ADDR_LINE_LEN_HI, 8'h00, 8'h00}, '{8'h30, 8'h77, READ_ZERO}};
	localparam bls_pix_type PIX [6] = '{'{1'b0, 8'h80, 10'h100, 10'h204, 10'h3FC, 8'h40, 8'h81, 8'hFF},
		'{1'b0, 8'hC0, 10'h040, 10'h000, 10'h100, 8'h50, 8'h40, 8'h80},
		'{1'b0, 8'h40, 10'h200, 10'h104, 10'h3FC, 8'h40, 8'h01, 8'hBF},
		'{1'b0, 8'h81, 10'h008, 10'h010, 10'h020, 8'h03, 8'h05, 8'h09},
		'{1'b1, 8'h80, 10'h0C8, 10'h1A0, 10'h234, 8'h32, 8'h68, 8'h8D},
		'{1'b0, 8'hFF, 10'h100, 10'h100, 10'h100, 8'h80, 8'h80, 8'h80}};
	logic        clk, nrst, regWr, regRd, pixClk, hsync, outValid, outReady, hold, slow;
	logic [7:0]  regAddr, regWrData, regRdData, q, gainRed, gainGreen, gainBlue, outRed, outGreen, outBlue;
	logic [9:0]  adcRed, adcGreen, adcBlue, dacRed, dacGreen, dacBlue;
	logic [5:0]  samplePhase;
	logic [11:0] lineLength;
	int          pixCnt, bad_count, check_count, t;
	bls_top dut (.clk, .nrst, .regAddr, .regWrData, .regWr, .regRd, .regRdData, .pixClk, .hsync, .adcRed,
		.adcGreen, .adcBlue, .dacRed, .dacGreen, .dacBlue, .gainRed, .gainGreen, .gainBlue, .samplePhase,
		.lineLength, .outRed, .outGreen, .outBlue, .outValid, .outReady);
	bls_sink_model sink (.clk, .nrst, .hold, .slow, .outValid, .outRed, .outGreen, .outBlue, .outReady);
	// system clock and free-running pixel clock
	always #5 clk = ~clk;
	always #62.5 pixClk = ~pixClk;
	// line timing: sync for the first four pixels of each line
	always @(negedge pixClk) begin
		pixCnt <= (pixCnt == LINE_PIX - 1) ? 0 : pixCnt + 1;
		hsync <= (pixCnt < 4);
	end
	// register bus cycles and waits
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		regAddr <= a;
		regWrData <= d;
		regWr <= 1'b1;
		@(posedge clk);
		regWr <= 1'b0;
	endtask
	task rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge clk);
		regRd <= 1'b0;
		#1 d = regRdData;
	endtask
	task adc(input logic [9:0] r, input logic [9:0] g, input logic [9:0] b);
		@(posedge clk);
		adcRed <= r;
		adcGreen <= g;
		adcBlue <= b;
	endtask
	task lines(input int n);
		repeat (n) @(negedge hsync);
	endtask
	task waitCap(input int n);
		int s;
		s = sink.capCount;
		repeat (500) begin
			if (sink.capCount >= s + n) break;
			@(posedge clk);
		end
		if (sink.capCount < s + n) begin
			bad_count++;
			$display("BAD waitCap exp %0d got %0d", n, sink.capCount - s);
		end
	endtask
	task wrap_up();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	// watchdog against a hung stream
	initial begin
		#800000;
		bad_count++;
		wrap_up();
	end
	// main sequence
	initial begin
		{clk, nrst, regWr, regRd, pixClk, hsync, hold, slow} = 8'h00;
		{regAddr, regWrData} = 16'h0000;
		{adcRed, adcGreen, adcBlue} = 30'h0000_0000;
		pixCnt = 0;
		bad_count = 0;
		check_count = 0;
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		#1;
		`CHK("gainRed", GAIN_RESET, gainRed)
		`CHK("dacRed", DAC_MID, dacRed)
		`CHK("lineLength", LINE_LEN_RESET, lineLength)
		rd(ADDR_GREEN_OFS, q);
		`CHK("greenOfs", OFS_NOMINAL, q)
		for (int i = 0; i < 7; i++) begin
			wr(REGS[i].a, REGS[i].d);
			rd(REGS[i].a, q);
			`CHK("regRead", REGS[i].q, q)
		end
		`CHK("gainBlue", 8'h33, gainBlue)
		`CHK("phase", 6'h3F, samplePhase)
		`CHK("lineLength", 12'h029, lineLength)
		for (int i = 0; i < 6; i++) begin
			wr(ADDR_CONFIG, {5'h00, PIX[i].y, 2'h0});
			wr(ADDR_RED_OFS, PIX[i].o);
			wr(ADDR_GREEN_OFS, PIX[i].o);
			wr(ADDR_BLUE_OFS, PIX[i].o);
			adc(PIX[i].r, PIX[i].g, PIX[i].b);
			waitCap(4);
			`CHK("outRed", PIX[i].er, sink.lastR)
			`CHK("outGreen", PIX[i].eg, sink.lastG)
			`CHK("outBlue", PIX[i].eb, sink.lastB)
		end
		@(posedge clk);
		nrst <= 1'b0;
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		#1;
		`CHK("gainGreen", GAIN_RESET, gainGreen)
		wr(ADDR_LINE_LEN_LO, 8'h29);
		wr(ADDR_LINE_LEN_HI, 8'h00);
		wr(ADDR_CONFIG, 8'h04);
		adc(10'h200, 10'h010, 10'h200);
		lines(20);
		`CHK("dacBlue", DAC_MID, dacBlue)
		`CHK("dacRed", DAC_MID, dacRed)
		`CHK("greenStep", 1'b1, dacGreen < DAC_MID)
		rd(ADDR_STATUS, q);
		`CHK("locked", 1'b1, q[0])
		wr(ADDR_CONFIG, 8'h00);
		adc(10'h020, 10'h000, 10'h000);
		lines(40);
		`CHK("redSteps", 1'b1, dacRed inside {10'h1FD, 10'h1FE})
		`CHK("dacBlue", DAC_MID, dacBlue)
		wr(ADDR_SERVO_CTRL, 8'h01);
		wr(ADDR_RED_OFS, 8'hA5);
		wr(ADDR_DAC_LOW, 8'h00);
		lines(17);
		`CHK("dacManual", 10'h294, dacRed)
		rd(ADDR_DAC_RD_R, q);
		`CHK("dacReadback", 8'hA5, q)
		wr(ADDR_GAIN_SECOND, 8'h99);
		wr(ADDR_RED_OFS, 8'h00);
		wr(ADDR_SERVO_CTRL, 8'h00);
		lines(20);
		`CHK("dacFloor", DAC_MIN, dacRed)
		wr(ADDR_RED_OFS, 8'h80);
		wr(ADDR_CONFIG, 8'h04);
		wr(ADDR_OUT_FMT, 8'h10);
		adc(10'h0C8, 10'h1A0, 10'h234);
		slow <= 1'b1;
		lines(1);
		repeat (3) begin
			@(negedge hsync);
			waitCap(1);
			`CHK("firstChroma", 8'h8D, sink.lastR)
			waitCap(1);
			`CHK("secondChroma", 8'h32, sink.lastR)
			`CHK("luma", 8'h68, sink.lastG)
		end
		slow <= 1'b0;
		@(negedge hsync);
		repeat (250) @(posedge clk);
		hold <= 1'b1;
		repeat (100) @(posedge clk);
		@(posedge pixClk);
		repeat (4) @(posedge clk);
		t = sink.capCount;
		hold <= 1'b0;
		repeat (8) @(posedge clk);
		`CHK("drainCount", 2, sink.capCount - t)
		wrap_up();
	end
endmodule
